// *** shared/dual_uart_pkg.sv ***
package dual_uart_pkg;

  // bus and channel geometry
  localparam int ADDR_W   = 3;
  localparam int DATA_W   = 8;
  localparam int NUM_CHAN = 2;
  localparam logic CHAN_A = 1'h0;
  localparam logic CHAN_B = 1'h1;

  // per-channel register offsets on the device
  localparam logic [ADDR_W-1:0] OFF_INT_ENABLE    = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_MODEM_CONTROL = 3'h4;
  localparam logic [ADDR_W-1:0] OFF_MODEM_STATUS  = 3'h6;

  // field positions
  localparam int CTL_RTS_BIT        = 1; // request-to-send control
  localparam int CTL_USER_BIT       = 3; // interrupt enable / user output
  localparam int IER_MODEM_BIT      = 3; // modem status interrupt enable
  localparam int MSR_TRAIL_RING_BIT = 2; // sticky ring-end event
  localparam int MSR_RING_BIT       = 6; // ring indicator, true polarity

  // reset and idle values
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] BUS_IDLE  = 8'hFF;

  // host controller register map
  localparam logic [ADDR_W-1:0] HREG_CMD    = 3'h0;
  localparam logic [ADDR_W-1:0] HREG_WDATA  = 3'h1;
  localparam logic [ADDR_W-1:0] HREG_RDATA  = 3'h2;
  localparam logic [ADDR_W-1:0] HREG_STATUS = 3'h3;
  localparam logic [ADDR_W-1:0] HREG_RESET  = 3'h4;
  localparam int CMD_ADDR_LSB    = 0;
  localparam int CMD_CHAN_BIT    = 3;
  localparam int CMD_READ_BIT    = 4;
  localparam int RESET_REQ_BIT   = 0;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_IRQ_A_BIT  = 1;
  localparam int STAT_IRQ_B_BIT  = 2;

  // strobe timing
  localparam int CLK_HZ        = 50_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int STROBE_NS     = 60;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 4;
  localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYC - 1);

  // host sequencer states
  typedef enum logic [1:0] {
    H_IDLE   = 2'b00,
    H_SETUP  = 2'b01,
    H_STROBE = 2'b10,
    H_HOLD   = 2'b11
  } host_state_t;

  // decoded bus access
  typedef struct packed {
    logic active;
    logic rd;
    logic chan;
  } bus_req_t;

endpackage

// *** shared/dual_uart_bus_if.sv ***
`timescale 1ns/1ps
interface dual_uart_bus_if;
  import dual_uart_pkg::*;

  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] host_data;
  logic              host_data_oe_n;
  logic [DATA_W-1:0] dev_data;
  logic              dev_data_oe_n;
  logic [DATA_W-1:0] data_bus;
  logic              chip_select_primary_n;
  logic              chip_select_secondary_n;
  logic              host_read_strobe_n;
  logic              host_write_strobe_n;
  logic              master_reset;
  logic              chan_a_interrupt_out;
  logic              chan_a_interrupt_oe_n;
  logic              chan_b_interrupt_out;
  logic              chan_b_interrupt_oe_n;
  logic              chan_a_irq_level;
  logic              chan_b_irq_level;

  // shared data bus: device wins, otherwise host, otherwise pulled high
  assign data_bus = !dev_data_oe_n ? dev_data :
                    (!host_data_oe_n ? host_data : BUS_IDLE);

  // interrupt wires with a pull-up when undriven
  assign chan_a_irq_level = chan_a_interrupt_oe_n ? 1'h1 : chan_a_interrupt_out;
  assign chan_b_irq_level = chan_b_interrupt_oe_n ? 1'h1 : chan_b_interrupt_out;

  modport device (
    input  addr,
    input  data_bus,
    input  chip_select_primary_n,
    input  chip_select_secondary_n,
    input  host_read_strobe_n,
    input  host_write_strobe_n,
    input  master_reset,
    output dev_data,
    output dev_data_oe_n,
    output chan_a_interrupt_out,
    output chan_a_interrupt_oe_n,
    output chan_b_interrupt_out,
    output chan_b_interrupt_oe_n
  );

  modport host (
    output addr,
    output host_data,
    output host_data_oe_n,
    output chip_select_primary_n,
    output chip_select_secondary_n,
    output host_read_strobe_n,
    output host_write_strobe_n,
    output master_reset,
    input  data_bus,
    input  chan_a_irq_level,
    input  chan_b_irq_level
  );

endinterface // dual_uart_bus_if

// *** design/dual_uart_host.sv ***
`timescale 1ns/1ps
module dual_uart_host
  import dual_uart_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic              mode_strap,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  input  wire logic              cmd_write,
  input  wire logic              cmd_read,
  output logic      [DATA_W-1:0] cmd_rdata,
  dual_uart_bus_if.host          bus
);

  typedef struct packed {
    host_state_t       state;
    logic [CNT_W-1:0]  cnt;
    logic [ADDR_W-1:0] dev_addr;
    logic              chan;
    logic              is_read;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rx_data;
    logic              reset_req;
    logic              irq_a;
    logic              irq_b;
    logic [DATA_W-1:0] rdata;
    logic              csp_n;
    logic              css_n;
    logic              rd_n;
    logic              wr_n;
    logic              data_oe_n;
    logic              mreset;
  } host_regs_t;

  localparam host_regs_t HOST_RESET = '{
    state: H_IDLE, cnt: '0, dev_addr: '0, chan: CHAN_A, is_read: 1'h0,
    wdata: REG_RESET, rx_data: REG_RESET, reset_req: 1'h0, irq_a: 1'h1,
    irq_b: 1'h1, rdata: REG_RESET, csp_n: 1'h1, css_n: 1'h1, rd_n: 1'h1,
    wr_n: 1'h1, data_oe_n: 1'h1, mreset: 1'h0
  };

  host_regs_t st;
  host_regs_t next_st;

  // command port, bus sequencer and pin drive
  always_comb begin
    logic busy;
    logic strobing;
    next_st       = st;
    busy          = 1'h0;
    strobing      = 1'h0;
    next_st.rdata = REG_RESET;
    next_st.irq_a = bus.chan_a_irq_level;
    next_st.irq_b = bus.chan_b_irq_level;
    if (cmd_read) begin
      case (cmd_addr)
        HREG_WDATA:  next_st.rdata = st.wdata;
        HREG_RDATA:  next_st.rdata = st.rx_data;
        HREG_RESET:  next_st.rdata[RESET_REQ_BIT] = st.reset_req;
        HREG_STATUS: begin
          next_st.rdata[STAT_BUSY_BIT]  = (st.state != H_IDLE);
          next_st.rdata[STAT_IRQ_A_BIT] = st.irq_a;
          next_st.rdata[STAT_IRQ_B_BIT] = st.irq_b;
        end
        default:     next_st.rdata = REG_RESET;
      endcase
    end
    if (cmd_write) begin
      case (cmd_addr)
        HREG_WDATA: next_st.wdata = cmd_wdata;
        HREG_RESET: next_st.reset_req = cmd_wdata[RESET_REQ_BIT];
        HREG_CMD: begin
          if (st.state == H_IDLE) begin // commands while busy are dropped
            next_st.dev_addr = cmd_wdata[CMD_ADDR_LSB +: ADDR_W];
            next_st.chan     = cmd_wdata[CMD_CHAN_BIT];
            next_st.is_read  = cmd_wdata[CMD_READ_BIT];
            next_st.state    = H_SETUP;
          end
        end
        default: ;
      endcase
    end
    case (st.state)
      H_IDLE:   ;
      H_SETUP: begin
        next_st.state = H_STROBE;
        next_st.cnt   = STROBE_LAST;
      end
      H_STROBE: begin
        if (st.cnt == '0) begin
          if (st.is_read) begin
            next_st.rx_data = bus.data_bus;
          end
          next_st.state = H_HOLD;
        end else begin
          next_st.cnt = st.cnt - CNT_W'(1);
        end
      end
      H_HOLD:   next_st.state = H_IDLE;
      default:  next_st.state = H_IDLE;
    endcase
    busy              = (next_st.state != H_IDLE);
    strobing          = (next_st.state == H_STROBE);
    next_st.data_oe_n = !(busy && !next_st.is_read);
    if (mode_strap) begin
      // separate strobes, one chip select per channel
      next_st.csp_n = !(busy && next_st.chan == CHAN_A);
      next_st.css_n = !(busy && next_st.chan == CHAN_B);
      next_st.rd_n  = !(strobing && next_st.is_read);  // [R05]
      next_st.wr_n  = !(strobing && !next_st.is_read); // [R06]
    end else begin
      // one chip select, direction line, channel on the second select
      next_st.csp_n = !strobing;
      next_st.css_n = next_st.chan;                    // [R12]
      next_st.wr_n  = busy ? next_st.is_read : 1'h1;   // [R07]
      next_st.rd_n  = 1'h1;                            // [R05]
    end
    next_st.mreset = mode_strap ? next_st.reset_req : !next_st.reset_req;
  end

  // state register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= HOST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // pins straight from the state register
  assign cmd_rdata               = st.rdata;
  assign bus.addr                = st.dev_addr;
  assign bus.host_data           = st.wdata;
  assign bus.host_data_oe_n      = st.data_oe_n;
  assign bus.chip_select_primary_n   = st.csp_n;
  assign bus.chip_select_secondary_n = st.css_n;
  assign bus.host_read_strobe_n  = st.rd_n;
  assign bus.host_write_strobe_n = st.wr_n;
  assign bus.master_reset        = st.mreset;

endmodule // dual_uart_host

// *** design/dual_uart_device.sv ***
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// Function
// R01 - channel A bit 3 enables interrupt, user low; with strap low only the user output follows the bit
// R02 - channel B control bit 3 does the same
// R03 - strap low: A pin is shared open-drain request
// R04 - strap low: B interrupt pin left undriven
// R05 - read strobe used only with strap high
// R06 - write strobe captures data, strap high
// R07 - strap low: write pin selects read or write
// R08 - software uses interrupt or user output, not both
// R09 - master reset polarity follows the strap
// R10 - ring rising edge raises enabled modem interrupt
// R11 - control bit 1 drives request-to-send low
// R12 - strap low: second select picks the channel
// R13 - strap is a static bus mode selection
module dual_uart_device
  import dual_uart_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      reset_n,
  input  wire logic      mode_strap,
  input  wire logic      chan_a_ring_indicator_n,
  input  wire logic      chan_b_ring_indicator_n,
  output logic           chan_a_user_output,
  output logic           chan_b_user_output,
  output logic           chan_a_request_to_send_n,
  output logic           chan_b_request_to_send_n,
  dual_uart_bus_if.device bus
);

  typedef struct packed {
    logic [NUM_CHAN-1:0][DATA_W-1:0] ctl;
    logic [NUM_CHAN-1:0][DATA_W-1:0] ier;
    logic [NUM_CHAN-1:0]             teri;
    logic [NUM_CHAN-1:0]             ring_prev_n;
    logic                            active_prev;
    logic [DATA_W-1:0]               rd_data;
    logic                            rd_oe_n;
    logic [NUM_CHAN-1:0]             int_out;
    logic [NUM_CHAN-1:0]             int_oe_n;
    logic [NUM_CHAN-1:0]             user_out;
    logic [NUM_CHAN-1:0]             rts_n;
  } dev_regs_t;

  localparam dev_regs_t DEV_RESET = '{
    ctl: '0, ier: '0, teri: '0, ring_prev_n: '1, active_prev: 1'h0,
    rd_data: REG_RESET, rd_oe_n: 1'h1, int_out: '0, int_oe_n: '1,
    user_out: '1, rts_n: '1
  };

  dev_regs_t st;
  dev_regs_t next_st;

  // turns the pin levels into one access request for the current bus mode
  function automatic bus_req_t decode_bus(
    input logic strap,
    input logic csp_n,
    input logic css_n,
    input logic rd_n,
    input logic wr_n
  );
    bus_req_t r;
    r = '0;
    if (strap) begin
      // separate strobes: a select and a strobe together
      r.active = (!csp_n || !css_n) && (!rd_n || !wr_n); // [R05] [R06]
      r.rd     = !rd_n;                                  // [R05]
      r.chan   = csp_n ? CHAN_B : CHAN_A;
    end else begin
      // combined mode: one select, a direction line, a channel line
      r.active = !csp_n;                                 // [R12]
      r.rd     = wr_n;                                   // [R07]
      r.chan   = css_n;                                  // [R12]
    end
    return r;
  endfunction

  // read multiplexer of one channel
  function automatic logic [DATA_W-1:0] read_reg(
    input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] ier_v,
    input logic [DATA_W-1:0] ctl_v,
    input logic              teri_v,
    input logic              ring_n_v
  );
    logic [DATA_W-1:0] r;
    r = REG_RESET;
    case (a)
      OFF_INT_ENABLE:    r = ier_v;
      OFF_MODEM_CONTROL: r = ctl_v;
      OFF_MODEM_STATUS: begin
        r[MSR_TRAIL_RING_BIT] = teri_v;
        r[MSR_RING_BIT]       = !ring_n_v;
      end
      default:           r = REG_RESET; // unmapped offsets read zero
    endcase
    return r;
  endfunction

  logic [NUM_CHAN-1:0] ring_n;
  assign ring_n = {chan_b_ring_indicator_n, chan_a_ring_indicator_n};

  // bus access, modem events, reset and pin functions
  always_comb begin
    bus_req_t            req;
    logic                start;
    logic                mr_active;
    logic [NUM_CHAN-1:0] pend;
    next_st   = st;
    pend      = '0;
    // the strap is only ever read as a level and never latched
    req       = decode_bus(mode_strap, bus.chip_select_primary_n,
                           bus.chip_select_secondary_n, bus.host_read_strobe_n,
                           bus.host_write_strobe_n);                   // [R13]
    // an access is taken once, at the edge where it becomes active
    start     = req.active && !st.active_prev;
    mr_active = mode_strap ? bus.master_reset : !bus.master_reset;     // [R09]
    next_st.active_prev = req.active;

    // read data stays on the bus for the whole read access
    if (!(req.active && req.rd)) begin
      next_st.rd_oe_n = 1'h1;
    end

    // per-channel register access and ring edge detection
    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      logic hit;
      hit = start && (req.chan == 1'(ch));
      // ring level delayed one cycle for edge detection
      next_st.ring_prev_n[ch] = ring_n[ch];

      // the addressed channel puts its register on the bus for the access
      if (hit && req.rd) begin
        next_st.rd_data = read_reg(bus.addr, st.ier[ch], st.ctl[ch],
                                   st.teri[ch], ring_n[ch]);
        next_st.rd_oe_n = 1'h0;
        if (bus.addr == OFF_MODEM_STATUS) begin
          next_st.teri[ch] = 1'h0; // status read clears the event
        end
      end

      // write data is taken from the bus at the edge that starts the access
      if (hit && !req.rd) begin
        case (bus.addr)
          OFF_INT_ENABLE:    next_st.ier[ch] = bus.data_bus;  // [R06]
          OFF_MODEM_CONTROL: next_st.ctl[ch] = bus.data_bus;  // [R06]
          default: ;
        endcase
      end

      // a ring ending in the same cycle as the clearing read is kept
      if (!st.ring_prev_n[ch] && ring_n[ch]) begin
        next_st.teri[ch] = 1'h1;                              // [R10]
      end
    end

    // master reset returns the channels to their reset state
    if (mr_active) begin
      next_st.ctl     = '0;
      next_st.ier     = '0;
      next_st.teri    = '0;
      next_st.rd_oe_n = 1'h1;
    end

    // pin functions derived from the new register values
    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      // an event only counts while its channel has modem interrupts enabled
      pend[ch] = next_st.ier[ch][IER_MODEM_BIT] && next_st.teri[ch]; // [R10]
      // with the strap high, one control bit serves both the interrupt pin and the user output
      next_st.user_out[ch] = !next_st.ctl[ch][CTL_USER_BIT];         // [R01] [R02]
      next_st.rts_n[ch]    = !next_st.ctl[ch][CTL_RTS_BIT];          // [R11]
    end

    // interrupt pin drive for the selected bus mode
    if (mode_strap) begin
      // separate strobes: a pin drives only while its control bit is set
      for (int ch = 0; ch < NUM_CHAN; ch++) begin
        next_st.int_out[ch]  = pend[ch];
        next_st.int_oe_n[ch] = !next_st.ctl[ch][CTL_USER_BIT];       // [R01] [R02]
      end
    end else begin
      // combined mode: pin A pulls low for either channel, pin B floats
      next_st.int_out[CHAN_A]  = 1'h0;                               // [R03]
      next_st.int_oe_n[CHAN_A] = !(pend[CHAN_A] || pend[CHAN_B]);    // [R03]
      next_st.int_out[CHAN_B]  = 1'h0;                               // [R04]
      next_st.int_oe_n[CHAN_B] = 1'h1;                               // [R04]
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= DEV_RESET;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign bus.dev_data              = st.rd_data;
  assign bus.dev_data_oe_n         = st.rd_oe_n;
  assign bus.chan_a_interrupt_out  = st.int_out[CHAN_A];
  assign bus.chan_a_interrupt_oe_n = st.int_oe_n[CHAN_A];
  assign bus.chan_b_interrupt_out  = st.int_out[CHAN_B];
  assign bus.chan_b_interrupt_oe_n = st.int_oe_n[CHAN_B];
  assign chan_a_user_output        = st.user_out[CHAN_A];
  assign chan_b_user_output        = st.user_out[CHAN_B];
  assign chan_a_request_to_send_n  = st.rts_n[CHAN_A];
  assign chan_b_request_to_send_n  = st.rts_n[CHAN_B];

endmodule // dual_uart_device

// *** verif/dual_uart_monitor.sv ***
`timescale 1ns/1ps
module dual_uart_monitor
  import dual_uart_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic mode_strap,
  input wire logic chip_select_primary_n,
  input wire logic chip_select_secondary_n,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic master_reset,
  input wire logic dev_data_oe_n,
  input wire logic chan_a_interrupt_out,
  input wire logic chan_a_interrupt_oe_n,
  input wire logic chan_b_interrupt_oe_n,
  input wire logic chan_a_user_output,
  input wire logic chan_b_user_output,
  input wire logic chan_a_request_to_send_n,
  input wire logic chan_b_request_to_send_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // strobe phase of one host transfer: three cycles low, then high
  sequence s_low3(logic s);
    !s [*3] ##1 s;
  endsequence

  a_user_tracks_a: assert property (mode_strap |-> chan_a_interrupt_oe_n == chan_a_user_output)
    else $error("channel A user output and interrupt enable disagree");
  a_user_tracks_b: assert property (mode_strap |-> chan_b_interrupt_oe_n == chan_b_user_output)
    else $error("channel B user output and interrupt enable disagree");
  a_shared_pull_low: assert property (!mode_strap && !chan_a_interrupt_oe_n |-> !chan_a_interrupt_out)
    else $error("shared interrupt driven high");
  a_b_pin_idle: assert property (!mode_strap |-> chan_b_interrupt_oe_n)
    else $error("channel B interrupt driven in combined mode");
  a_read_strobe_held: assert property (!mode_strap |-> host_read_strobe_n)
    else $error("read strobe used in combined mode");
  a_write_strobe_width: assert property (mode_strap && $fell(host_write_strobe_n)
    |-> s_low3(host_write_strobe_n))
    else $error("write strobe width wrong");
  a_read_drive_sep: assert property (mode_strap && $fell(dev_data_oe_n)
    |-> $past(!host_read_strobe_n && !(chip_select_primary_n && chip_select_secondary_n)))
    else $error("data driven without read strobe");
  a_read_drive_comb: assert property (!mode_strap && $fell(dev_data_oe_n)
    |-> $past(host_write_strobe_n && !chip_select_primary_n))
    else $error("data driven without read direction");
  a_select_comb: assert property (!mode_strap && $fell(chip_select_primary_n)
    |-> s_low3(chip_select_primary_n) and $stable(chip_select_secondary_n) [*3])
    else $error("combined select cycle malformed");
  a_master_clear: assert property ((mode_strap ? master_reset : !master_reset)
    |=> chan_a_request_to_send_n && chan_b_request_to_send_n && chan_a_user_output)
    else $error("master reset did not clear outputs");
endmodule // dual_uart_monitor

// *** verif/test_dual_uart_host_pin_logic.sv ***
`timescale 1ns/1ps
module test_dual_uart_host_pin_logic;
  import dual_uart_pkg::*;
  logic              sys_clk;
  logic              reset_n;
  logic              mode_strap;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_wdata;
  logic              cmd_write;
  logic              cmd_read;
  logic [DATA_W-1:0] cmd_rdata;
  logic              ring_a_n;
  logic              ring_b_n;
  logic              user_a;
  logic              user_b;
  logic              rts_a_n;
  logic              rts_b_n;
  logic [DATA_W-1:0] rv;
  logic              st;
  int                fail_count;
  int                samples_checked;
  int                cycles;

  dual_uart_bus_if bus_if ();
  dual_uart_host dual_uart_host_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .mode_strap(mode_strap), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_rdata(cmd_rdata), .bus(bus_if));
  dual_uart_device dual_uart_device_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .mode_strap(mode_strap), .chan_a_ring_indicator_n(ring_a_n),
    .chan_b_ring_indicator_n(ring_b_n), .chan_a_user_output(user_a),
    .chan_b_user_output(user_b), .chan_a_request_to_send_n(rts_a_n),
    .chan_b_request_to_send_n(rts_b_n), .bus(bus_if));
  dual_uart_monitor dual_uart_monitor_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .mode_strap(mode_strap), .chip_select_primary_n(bus_if.chip_select_primary_n),
    .chip_select_secondary_n(bus_if.chip_select_secondary_n),
    .host_read_strobe_n(bus_if.host_read_strobe_n),
    .host_write_strobe_n(bus_if.host_write_strobe_n), .master_reset(bus_if.master_reset),
    .dev_data_oe_n(bus_if.dev_data_oe_n), .chan_a_interrupt_out(bus_if.chan_a_interrupt_out),
    .chan_a_interrupt_oe_n(bus_if.chan_a_interrupt_oe_n),
    .chan_b_interrupt_oe_n(bus_if.chan_b_interrupt_oe_n), .chan_a_user_output(user_a),
    .chan_b_user_output(user_b), .chan_a_request_to_send_n(rts_a_n),
    .chan_b_request_to_send_n(rts_b_n));

  // 50 MHz clock
  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one-cycle command port write and read
  task automatic host_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cmd_write <= 1'h1;
    cmd_addr  <= a;
    cmd_wdata <= d;
    @(posedge sys_clk);
    cmd_write <= 1'h0;
  endtask

  task automatic host_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    cmd_read <= 1'h1;
    cmd_addr <= a;
    @(posedge sys_clk);
    cmd_read <= 1'h0;
    #1 d = cmd_rdata;
  endtask

  // full device transfer through the host sequencer
  task automatic xfer(input logic rd, input logic ch, input logic [2:0] off,
                      input logic [7:0] wd, output logic [7:0] d);
    logic [7:0] c;
    logic [7:0] s;
    int         n;
    c = 8'h00;
    c[CMD_READ_BIT] = rd;
    c[CMD_CHAN_BIT] = ch;
    c[2:0] = off;
    n = 0;
    host_wr(HREG_WDATA, wd);
    host_wr(HREG_CMD, c);
    do begin
      host_rd(HREG_STATUS, s);
      n++;
    end while (s[STAT_BUSY_BIT] !== 1'h0 && n < 20);
    check(8'(s[STAT_BUSY_BIT]), 8'h00);
    host_rd(HREG_RDATA, d);
  endtask

  // irq wire levels as seen by the host: {B, A}
  task automatic chk_irq(input logic ea, input logic eb);
    repeat (3) @(posedge sys_clk);
    host_rd(HREG_STATUS, rv);
    check(8'({rv[STAT_IRQ_B_BIT], rv[STAT_IRQ_A_BIT]}), 8'({eb, ea}));
  endtask

  task automatic ring(input logic ch);
    @(posedge sys_clk);
    if (ch) ring_b_n <= 1'h0;
    else ring_a_n <= 1'h0;
    repeat (4) @(posedge sys_clk);
    ring_a_n <= 1'h1;
    ring_b_n <= 1'h1;
    repeat (4) @(posedge sys_clk);
  endtask

  initial begin
    reset_n = 1'h0;
    mode_strap = 1'h1;
    cmd_addr = 3'h0;
    cmd_wdata = 8'h00;
    cmd_write = 1'h0;
    cmd_read = 1'h0;
    ring_a_n = 1'h1;
    ring_b_n = 1'h1;
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    // separate strobes first, then combined read/write mode
    for (int m = 1; m >= 0; m--) begin
      st = 1'(m);
      reset_n <= 1'h0;
      mode_strap <= st;
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'h1;
      @(posedge sys_clk);
      #1;
      check(8'({user_a, user_b, rts_a_n, rts_b_n}), 8'h0F);
      xfer(1'h0, CHAN_A, OFF_MODEM_CONTROL, 8'h0A, rv);
      check(8'({user_a, rts_a_n, user_b}), 8'h01);
      xfer(1'h0, CHAN_B, OFF_MODEM_CONTROL, 8'h02, rv);
      check(8'({user_b, rts_b_n, rts_a_n}), 8'h04);
      xfer(1'h1, CHAN_A, OFF_MODEM_CONTROL, 8'h00, rv);
      check(rv, 8'h0A);
      xfer(1'h1, CHAN_B, OFF_MODEM_CONTROL, 8'h00, rv);
      check(rv, 8'h02);
      chk_irq(!st, 1'h1);
      xfer(1'h0, CHAN_A, OFF_INT_ENABLE, 8'h08, rv); // channel A used for its interrupt
      @(posedge sys_clk);
      ring_a_n <= 1'h0;
      repeat (4) @(posedge sys_clk);
      xfer(1'h1, CHAN_A, OFF_MODEM_STATUS, 8'h00, rv);
      check(rv, 8'h40);
      @(posedge sys_clk);
      ring_a_n <= 1'h1;
      repeat (4) @(posedge sys_clk);
      chk_irq(st, 1'h1);
      xfer(1'h1, CHAN_A, OFF_MODEM_STATUS, 8'h00, rv);
      check(rv, 8'h04);
      chk_irq(!st, 1'h1);
      ring(CHAN_B);
      chk_irq(!st, 1'h1);
      xfer(1'h0, CHAN_B, OFF_MODEM_CONTROL, 8'h08, rv);
      check(8'({user_b, rts_b_n}), 8'h01);
      xfer(1'h0, CHAN_B, OFF_INT_ENABLE, 8'h08, rv);
      chk_irq(1'h0, 1'h1);
      host_wr(HREG_RESET, 8'h01);
      host_wr(HREG_RESET, 8'h00);
      check(8'({user_a, rts_a_n, user_b}), 8'h07);
      chk_irq(1'h1, 1'h1);
      xfer(1'h1, CHAN_A, OFF_MODEM_CONTROL, 8'h00, rv);
      check(rv, 8'h00);
    end
    complete_run();
  end
endmodule // test_dual_uart_host_pin_logic
